//--- src/csc_pkg.sv
// What this block does
// - One cursor register: display position and access pointer
// - Cursor steps by selected direction after each access
// - Cursor on first layer, or third with three
// - No cursor outside its layer's memory region
// - Dummy cursor only graphics on, text off
// - Without text screen, only bar cursor drawn
// - Mixed first layer: block on text, bar on graphics
// - Pixel-step horizontal scroll via scroll command
// - Pixel scroll shared by both screen blocks
// - On-chip ROM 160 chars, plus 64 RAM chars
// - External ROM at f000-f7ff or f000-ffff by height
// - External ROM 192 chars, always mixed with RAM
// - Generator RAM 64 beside ROM, at f000 too
// - Generator RAM base set by base command
// - 256 codes at once, banks of 64
// - Height select 0: 1-8 rows, 1: 9-16
// - ROM source chosen per code and source select
// - Correction forces bit 6 of second RAM area
package csc_pkg;
  localparam int AXI_AW = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CURSOR = 8'h04;
  localparam logic [7:0] OFS_DIR = 8'h08;
  localparam logic [7:0] OFS_PITCH = 8'h0c;
  localparam logic [7:0] OFS_L1_START = 8'h10;
  localparam logic [7:0] OFS_L1_END = 8'h14;
  localparam logic [7:0] OFS_L3_START = 8'h18;
  localparam logic [7:0] OFS_L3_END = 8'h1c;
  localparam logic [7:0] OFS_TEXT_SPLIT = 8'h20;
  localparam logic [7:0] OFS_MEM_DATA = 8'h24;
  localparam logic [7:0] OFS_HSCROLL = 8'h28;
  localparam logic [7:0] OFS_CG_BASE = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  // Control register fields
  localparam int CTL_SRC = 0;
  localparam int CTL_BIT6 = 1;
  localparam int CTL_HEIGHT = 2;
  localparam int CTL_THREE = 3;
  localparam int CTL_TEXT_ON = 4;
  localparam int CTL_GFX_ON = 5;
  localparam int CTL_BLOCK = 6;
  localparam int CTL_MIXED = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] PITCH_RST = 8'h28;
  localparam logic [15:0] L_END_RST = 16'hffff;
  localparam int HSCROLL_W = 3;
  // Character generator map
  localparam logic [15:0] EXT_ROM_BASE = 16'hf000;
  localparam logic [15:0] EXT_ROM_END8 = 16'hf7ff;
  localparam logic [15:0] EXT_ROM_END16 = 16'hffff;
  localparam int ROM_CHARS = 160;
  localparam int CGRAM_MIX_CHARS = 64;
  localparam int EXT_ALONE_CHARS = 256;
  localparam int EXT_MIX_CHARS = 192;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {DIR_RIGHT, DIR_LEFT, DIR_UP, DIR_DOWN} csc_dir_t;
  typedef enum logic [1:0] {SRC_INT_ROM, SRC_EXT_ROM, SRC_CGRAM} csc_src_t;
  // Codes 80-9f and e0-ff belong to generator RAM
  function automatic logic is_ram_code(input logic [7:0] code);
    return code[7] && (code[6:5] == 2'b00 || code[6:5] == 2'b11);
  endfunction
endpackage

//--- src/csc_cg_if.sv
`timescale 1ns/1ps
interface csc_cg_if;
  import csc_pkg::*;
  logic [7:0] code;
  logic [3:0] row;
  logic [15:0] base;
  logic src_ext;
  logic bit6_fix;
  logic tall;
  logic [15:0] addr;
  csc_src_t src;
  modport map (input code, row, base, src_ext, bit6_fix, tall, output addr, src);
  modport user (output code, row, base, src_ext, bit6_fix, tall, input addr, src);
endinterface

//--- src/csc_cg_map.sv
`timescale 1ns/1ps
module csc_cg_map (
  csc_cg_if.map cg
);
  import csc_pkg::*;
  logic [7:0] code_eff;
  logic [15:0] offset;

  // Second RAM area lands right after the first when corrected, e0-ff read as a0-bf
  always_comb begin
    code_eff = cg.code;
    if (cg.bit6_fix && is_ram_code(cg.code)) begin
      code_eff[6] = 1'b0;
    end
  end

  // Tall cells use 16 rows per code, short ones 8
  always_comb begin
    if (cg.tall) begin
      offset = {4'h0, code_eff, cg.row};
    end else begin
      offset = {5'h00, code_eff, cg.row[2:0]};
    end
  end

  // Source picked from code value and source select
  always_comb begin
    if (is_ram_code(cg.code)) begin
      cg.src = SRC_CGRAM;
      cg.addr = cg.base + offset;
    end else if (cg.src_ext) begin
      cg.src = SRC_EXT_ROM;
      cg.addr = EXT_ROM_BASE + offset;
    end else begin
      cg.src = SRC_INT_ROM;
      cg.addr = {8'h00, cg.code};
    end
  end
endmodule

//--- src/csc_top.sv
`timescale 1ns/1ps
module csc_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [csc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [csc_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [15:0] vram_addr,
  output logic [7:0] vram_wdata,
  output logic vram_we,
  output logic vram_re,
  input wire logic [7:0] vram_rdata,
  input wire logic [7:0] char_code,
  input wire logic [3:0] char_row,
  output logic cursor_show,
  output logic cursor_block,
  output logic [csc_pkg::HSCROLL_W-1:0] hscroll_px,
  output logic [15:0] cg_addr,
  output csc_pkg::csc_src_t cg_src
);
  import csc_pkg::*;

  typedef enum logic [2:0] {RD_IDLE, RD_DECODE, RD_ISSUE, RD_CAPTURE, RD_RESP} csc_rd_t;

  logic [7:0] ctrl_ff;
  logic [15:0] csr_ff;
  csc_dir_t dir_ff;
  logic [7:0] pitch_ff;
  logic [15:0] l1s_ff, l1e_ff, l3s_ff, l3e_ff, split_ff, cgbase_ff;
  logic [HSCROLL_W-1:0] hscroll_ff;
  logic aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff;
  logic [AXI_AW-1:0] awaddr_ff, araddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic arready_ff, rvalid_ff;
  logic [31:0] rdata_ff;
  csc_rd_t rd_ff;
  logic [15:0] vaddr_ff;
  logic [7:0] vwdata_ff;
  logic vwe_ff, vre_ff;
  logic show_ff, block_ff;
  logic [15:0] cg_addr_ff;
  csc_src_t cg_src_ff;
  logic do_write, wr_mem, rd_step, in_region;
  logic [15:0] lay_start, lay_end, nxt_csr;
  logic [31:0] wr_word;

  // Byte lanes merge into the old register value
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Step in address units, wrapping in the 64K space
  function automatic logic [15:0] step_addr(input logic [15:0] a, input csc_dir_t d,
                                            input logic [7:0] p);
    case (d)
      DIR_RIGHT: return a + 16'h0001;
      DIR_LEFT: return a - 16'h0001;
      DIR_UP: return a - {8'h00, p};
      DIR_DOWN: return a + {8'h00, p};
      default: return a;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [AXI_AW-1:0] a);
    return a[1:0] == 2'b00 && a <= OFS_STATUS;
  endfunction

  function automatic logic [31:0] reg_value(input logic [AXI_AW-1:0] a);
    case (a)
      OFS_CTRL: return {24'h000000, ctrl_ff};
      OFS_CURSOR: return {16'h0000, csr_ff};
      OFS_DIR: return {30'h00000000, dir_ff};
      OFS_PITCH: return {24'h000000, pitch_ff};
      OFS_L1_START: return {16'h0000, l1s_ff};
      OFS_L1_END: return {16'h0000, l1e_ff};
      OFS_L3_START: return {16'h0000, l3s_ff};
      OFS_L3_END: return {16'h0000, l3e_ff};
      OFS_TEXT_SPLIT: return {16'h0000, split_ff};
      OFS_HSCROLL: return {29'h00000000, hscroll_ff};
      OFS_CG_BASE: return {16'h0000, cgbase_ff};
      OFS_STATUS: return {29'h00000000, in_region, block_ff, show_ff};
      default: return 32'h00000000;
    endcase
  endfunction

  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_mem = do_write && awaddr_ff == OFS_MEM_DATA;
  assign rd_step = rd_ff == RD_DECODE && araddr_ff == OFS_MEM_DATA && !wr_mem;
  // Process form so register reads inside the function wake it too
  always_comb begin
    wr_word = wmerge(reg_value(awaddr_ff), wdata_ff, wstrb_ff);
  end

  // Write address and data taken in either order
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      awaddr_ff <= '0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        aw_held_ff <= 1'b1;
        awready_ff <= 1'b0;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
        w_held_ff <= 1'b1;
        wready_ff <= 1'b0;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= addr_ok(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Software-written configuration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= CTRL_RST;
      dir_ff <= DIR_RIGHT;
      pitch_ff <= PITCH_RST;
      l1s_ff <= ADDR_RST;
      l1e_ff <= L_END_RST;
      l3s_ff <= ADDR_RST;
      l3e_ff <= L_END_RST;
      split_ff <= ADDR_RST;
      hscroll_ff <= '0;
      cgbase_ff <= ADDR_RST;
    end else if (do_write) begin
      case (awaddr_ff)
        OFS_CTRL: ctrl_ff <= wr_word[7:0];
        OFS_DIR: dir_ff <= csc_dir_t'(wr_word[1:0]);
        OFS_PITCH: pitch_ff <= wr_word[7:0];
        OFS_L1_START: l1s_ff <= wr_word[15:0];
        OFS_L1_END: l1e_ff <= wr_word[15:0];
        OFS_L3_START: l3s_ff <= wr_word[15:0];
        OFS_L3_END: l3e_ff <= wr_word[15:0];
        OFS_TEXT_SPLIT: split_ff <= wr_word[15:0];
        OFS_HSCROLL: hscroll_ff <= wr_word[HSCROLL_W-1:0];
        OFS_CG_BASE: cgbase_ff <= wr_word[15:0];
        default: ;
      endcase
    end
  end

  // One pointer for display and access; a load beats a step
  always_comb begin
    nxt_csr = csr_ff;
    if (do_write && awaddr_ff == OFS_CURSOR) begin
      nxt_csr = wr_word[15:0];
    end else begin
      if (wr_mem) begin
        nxt_csr = step_addr(nxt_csr, dir_ff, pitch_ff);
      end
      if (rd_step) begin
        nxt_csr = step_addr(nxt_csr, dir_ff, pitch_ff);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      csr_ff <= ADDR_RST;
    end else begin
      csr_ff <= nxt_csr;
    end
  end

  // Display memory strobes, one cycle each
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vaddr_ff <= ADDR_RST;
      vwdata_ff <= 8'h00;
      vwe_ff <= 1'b0;
      vre_ff <= 1'b0;
    end else begin
      vwe_ff <= wr_mem;
      vre_ff <= rd_step;
      if (wr_mem) begin
        vaddr_ff <= csr_ff;
        vwdata_ff <= wr_word[7:0];
      end else if (rd_step) begin
        vaddr_ff <= csr_ff;
      end
    end
  end

  // Read path; memory reads hold the bus until data returns
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_ff <= RD_IDLE;
      arready_ff <= 1'b1;
      araddr_ff <= '0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else begin
      case (rd_ff)
        RD_IDLE: begin
          if (s_axi_arvalid && arready_ff) begin
            araddr_ff <= s_axi_araddr;
            arready_ff <= 1'b0;
            rd_ff <= RD_DECODE;
          end
        end
        RD_DECODE: begin
          if (araddr_ff == OFS_MEM_DATA) begin
            if (!wr_mem) begin
              rd_ff <= RD_ISSUE;
            end
          end else begin
            rdata_ff <= reg_value(araddr_ff);
            rresp_ff <= addr_ok(araddr_ff) ? RESP_OKAY : RESP_SLVERR;
            rvalid_ff <= 1'b1;
            rd_ff <= RD_RESP;
          end
        end
        RD_ISSUE: rd_ff <= RD_CAPTURE;
        RD_CAPTURE: begin
          rdata_ff <= {24'h000000, vram_rdata};
          rresp_ff <= RESP_OKAY;
          rvalid_ff <= 1'b1;
          rd_ff <= RD_RESP;
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
            rd_ff <= RD_IDLE;
          end
        end
        default: rd_ff <= RD_IDLE;
      endcase
    end
  end

  // Cursor layer follows layer count
  assign lay_start = ctrl_ff[CTL_THREE] ? l3s_ff : l1s_ff;
  assign lay_end = ctrl_ff[CTL_THREE] ? l3e_ff : l1e_ff;
  assign in_region = csr_ff >= lay_start && csr_ff <= lay_end;

  // Cursor visibility and shape; graphics-only gives a bar
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      show_ff <= 1'b0;
      block_ff <= 1'b0;
    end else begin
      show_ff <= in_region && (ctrl_ff[CTL_TEXT_ON] || ctrl_ff[CTL_GFX_ON]);
      if (!ctrl_ff[CTL_TEXT_ON]) begin
        block_ff <= 1'b0;
      end else if (ctrl_ff[CTL_MIXED]) begin
        block_ff <= ctrl_ff[CTL_BLOCK] && csr_ff < split_ff;
      end else begin
        block_ff <= ctrl_ff[CTL_BLOCK];
      end
    end
  end

  // Character generator address, registered for the scan side
  csc_cg_if cg ();
  assign cg.code = char_code;
  assign cg.row = char_row;
  assign cg.base = cgbase_ff;
  assign cg.src_ext = ctrl_ff[CTL_SRC];
  assign cg.bit6_fix = ctrl_ff[CTL_BIT6];
  assign cg.tall = ctrl_ff[CTL_HEIGHT];

  csc_cg_map u_map (
    .cg(cg)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cg_addr_ff <= ADDR_RST;
      cg_src_ff <= SRC_INT_ROM;
    end else begin
      cg_addr_ff <= cg.addr;
      cg_src_ff <= cg.src;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign vram_addr = vaddr_ff;
  assign vram_wdata = vwdata_ff;
  assign vram_we = vwe_ff;
  assign vram_re = vre_ff;
  assign cursor_show = show_ff;
  assign cursor_block = block_ff;
  // One shift for the whole window, both blocks alike
  assign hscroll_px = hscroll_ff;
  assign cg_addr = cg_addr_ff;
  assign cg_src = cg_src_ff;

  // Memory strobes use the pre-step cursor
  chk_access_addr: assert property (@(posedge clk) disable iff (!arst_n)
    (vwe_ff || vre_ff) |-> vaddr_ff == $past(csr_ff))
    else $error("access address is not the cursor");

  chk_cursor_step: assert property (@(posedge clk) disable iff (!arst_n)
    vwe_ff |-> csr_ff == step_addr(vaddr_ff, dir_ff, pitch_ff))
    else $error("cursor did not step after write");

  chk_read_step: assert property (@(posedge clk) disable iff (!arst_n)
    rd_step |=> csr_ff != $past(csr_ff) || $past(dir_ff) == DIR_UP
      || $past(dir_ff) == DIR_DOWN)
    else $error("cursor did not step after read");

  chk_cursor_region: assert property (@(posedge clk) disable iff (!arst_n)
    !in_region |=> !show_ff)
    else $error("cursor shown outside its layer");

  chk_cursor_layer: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl_ff[CTL_THREE] && (csr_ff < l3s_ff || csr_ff > l3e_ff) |=> !cursor_show)
    else $error("cursor not held to third layer");

  chk_bar_no_text: assert property (@(posedge clk) disable iff (!arst_n)
    !ctrl_ff[CTL_TEXT_ON] |=> !cursor_block)
    else $error("block cursor without text screen");

  chk_mixed_shape: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl_ff[CTL_TEXT_ON] && ctrl_ff[CTL_MIXED] && ctrl_ff[CTL_BLOCK] && csr_ff < split_ff
    |=> cursor_block)
    else $error("no block cursor over text area");

  chk_ext_range: assert property (@(posedge clk) disable iff (!arst_n)
    cg_src_ff == SRC_EXT_ROM |-> cg_addr_ff >= EXT_ROM_BASE
      && ($past(ctrl_ff[CTL_HEIGHT]) || cg_addr_ff <= EXT_ROM_END8))
    else $error("external glyph address out of range");

  chk_bit6_fold: assert property (@(posedge clk) disable iff (!arst_n)
    cg_src_ff == SRC_CGRAM && $past(ctrl_ff[CTL_BIT6]) && !$past(ctrl_ff[CTL_HEIGHT])
    |-> ((cg_addr_ff - $past(cgbase_ff)) & 16'h0200) == 16'h0000)
    else $error("bit 6 not folded");

  chk_write_resp: assert property (@(posedge clk) disable iff (!arst_n)
    do_write |=> bvalid_ff ##0 !awready_ff && !wready_ff)
    else $error("write response missing");
endmodule

//--- tb/csc_vram_model.sv
`timescale 1ns/1ps
module csc_vram_model (
  input wire logic clk,
  input wire logic [15:0] vram_addr,
  input wire logic [7:0] vram_wdata,
  input wire logic vram_we,
  input wire logic vram_re,
  output logic [7:0] vram_rdata
);
  logic [7:0] mem_ff [logic [15:0]];

  // Byte held only in the cycle after a read strobe; toggling otherwise
  // so that a sample one cycle late never happens to see the right value
  always @(posedge clk) begin
    if (vram_we) begin
      mem_ff[vram_addr] = vram_wdata;
    end
    if (vram_re) begin
      vram_rdata <= mem_ff.exists(vram_addr) ? mem_ff[vram_addr] : 8'h00;
    end else begin
      vram_rdata <= ~vram_rdata;
    end
  end
endmodule

//--- tb/csc_top_tb.sv
`timescale 1ns/1ps
module csc_top_tb;
  import csc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [7:0] char_code = 8'h00;
  logic [3:0] char_row = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, vram_we, vram_re, cursor_show, cursor_block;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd_data;
  logic [15:0] vram_addr, cg_addr, we_addr, saved;
  logic [7:0] vram_wdata, vram_rdata, we_data;
  logic [HSCROLL_W-1:0] hscroll_px;
  csc_src_t cg_src;
  int mismatches = 0, num_checks = 0, we_cnt = 0, re_cnt = 0, n0;
  logic [7:0] rst_ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h28, 8'h2c};
  logic [31:0] rst_val [9] = '{0, 0, 0, 32'h28, 0, 32'hffff, 32'hffff, 0, 0};
  logic [15:0] step_exp [4] = '{16'h1001, 16'h0fff, 16'h0fd8, 16'h1028};

  csc_top DUT (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .vram_addr(vram_addr), .vram_wdata(vram_wdata), .vram_we(vram_we), .vram_re(vram_re),
    .vram_rdata(vram_rdata), .char_code(char_code), .char_row(char_row),
    .cursor_show(cursor_show), .cursor_block(cursor_block), .hscroll_px(hscroll_px),
    .cg_addr(cg_addr), .cg_src(cg_src));

  csc_vram_model mem (.clk(clk), .vram_addr(vram_addr), .vram_wdata(vram_wdata),
    .vram_we(vram_we), .vram_re(vram_re), .vram_rdata(vram_rdata));

  always #5 clk = ~clk;

  // Strobe counters catch missing or doubled pulses
  always @(posedge clk) begin
    if (vram_we) begin
      we_cnt++;
      we_addr = vram_addr;
      we_data = vram_wdata;
    end
    if (vram_re) begin
      re_cnt++;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_ok, w_ok, got;
    n = 0;
    got = 1'b0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 200) begin
      @(posedge clk);
      n++;
      if (aw_ok && w_ok && bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        got = 1'b1;
        break;
      end
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // A write that never answers counts against the run
    if (!got) begin
      mismatches++;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    logic ar_ok, got;
    n = 0;
    got = 1'b0;
    ar_ok = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 200) begin
      @(posedge clk);
      n++;
      if (ar_ok && rvalid) begin
        rd_data = rdata;
        resp = rresp;
        rready <= 1'b0;
        got = 1'b1;
        break;
      end
      if (!ar_ok && arready) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
    end
    // A read that never answers counts against the run
    if (!got) begin
      mismatches++;
    end
  endtask

  // Display configuration then cursor position, levels checked once settled
  task automatic disp(input logic [7:0] c, input logic [15:0] cur, input logic s, input logic b);
    axi_wr(OFS_CTRL, {24'h0, c});
    axi_wr(OFS_CURSOR, {16'h0, cur});
    repeat (3) @(posedge clk);
    chk("cursor_show", cursor_show, s);
    chk("cursor_block", cursor_block, b);
  endtask

  task automatic cg(input logic [7:0] c, input logic [7:0] code, input logic [3:0] row,
                    input logic [15:0] ea, input csc_src_t es);
    axi_wr(OFS_CTRL, {24'h0, c});
    char_code <= code;
    char_row <= row;
    repeat (3) @(posedge clk);
    chk("cg_addr", cg_addr, ea);
    chk("cg_src", 32'(cg_src), 32'(es));
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      axi_rd(rst_ofs[i]);
      chk("reset value", rd_data, rst_val[i]);
    end
    axi_rd(8'h34);
    chk("unmapped resp", resp, RESP_SLVERR);
    chk("unmapped data", rd_data, 32'h0);
    axi_wr(8'h05, 32'h1234);
    chk("unaligned resp", resp, RESP_SLVERR);
    axi_rd(OFS_CURSOR);
    chk("cursor untouched", rd_data, 32'h0);
    $display("test registers done");
    // Every direction from the same start, writing through the data port
    for (int i = 0; i < 4; i++) begin
      axi_wr(OFS_DIR, 32'(i));
      axi_wr(OFS_CURSOR, 32'h1000);
      n0 = we_cnt;
      axi_wr(OFS_MEM_DATA, 32'(8'h50 + i));
      repeat (2) @(posedge clk);
      chk("we pulses", we_cnt - n0, 1);
      chk("we addr", we_addr, 16'h1000);
      chk("we data", we_data, 8'h50 + i);
      axi_rd(OFS_CURSOR);
      chk("cursor step", rd_data, step_exp[i]);
    end
    axi_wr(OFS_DIR, 32'h0);
    axi_wr(OFS_CURSOR, 32'hffff);
    axi_wr(OFS_MEM_DATA, 32'h77);
    axi_rd(OFS_CURSOR);
    chk("cursor wrap", rd_data, 32'h0);
    // Off-screen read with the cursor saved and put back afterwards
    axi_rd(OFS_CURSOR);
    saved = rd_data[15:0];
    axi_wr(OFS_CURSOR, 32'h1000);
    n0 = re_cnt;
    axi_rd(OFS_MEM_DATA);
    chk("mem read data", rd_data, 32'h53);
    chk("re pulses", re_cnt - n0, 1);
    axi_rd(OFS_CURSOR);
    chk("read step", rd_data, 32'h1001);
    axi_wr(OFS_CURSOR, {16'h0, saved});
    axi_rd(OFS_CURSOR);
    chk("cursor restored", rd_data, 32'h0);
    $display("test memory port done");
    axi_wr(OFS_L1_START, 32'h0);
    axi_wr(OFS_L1_END, 32'h03ff);
    axi_wr(OFS_L3_START, 32'h2000);
    axi_wr(OFS_L3_END, 32'h27ff);
    axi_wr(OFS_TEXT_SPLIT, 32'h0200);
    disp(8'h10, 16'h0100, 1'b1, 1'b0);
    disp(8'h50, 16'h0100, 1'b1, 1'b1);
    disp(8'h10, 16'h0500, 1'b0, 1'b0);
    disp(8'h18, 16'h0100, 1'b0, 1'b0);
    disp(8'h18, 16'h2100, 1'b1, 1'b0);
    disp(8'h60, 16'h0100, 1'b1, 1'b0);
    disp(8'h40, 16'h0100, 1'b0, 1'b0);
    disp(8'hf0, 16'h0100, 1'b1, 1'b1);
    disp(8'hf0, 16'h0300, 1'b1, 1'b0);
    $display("test cursor display done");
    axi_wr(OFS_HSCROLL, 32'h5);
    repeat (3) @(posedge clk);
    chk("hscroll", hscroll_px, 3'h5);
    axi_wr(OFS_HSCROLL, 32'hff);
    axi_rd(OFS_HSCROLL);
    chk("hscroll read", rd_data, 32'h7);
    chk("hscroll out", hscroll_px, 3'h7);
    // Host blanks the newly exposed line itself
    axi_wr(OFS_CURSOR, 32'h0300);
    axi_wr(OFS_MEM_DATA, 32'h0);
    repeat (2) @(posedge clk);
    chk("blank addr", we_addr, 16'h0300);
    chk("blank data", we_data, 8'h00);
    $display("test scroll done");
    axi_wr(OFS_CG_BASE, 32'h4800);
    // Glyph row for code 80 row 2, spare low bits kept zero
    axi_wr(OFS_CURSOR, 32'h4c02);
    axi_wr(OFS_MEM_DATA, 32'hf8);
    axi_wr(OFS_CURSOR, 32'h4c02);
    axi_rd(OFS_MEM_DATA);
    chk("glyph row", rd_data, 32'hf8);
    cg(8'h00, 8'h41, 4'h3, 16'h0041, SRC_INT_ROM);
    cg(8'h00, 8'h80, 4'h2, 16'h4c02, SRC_CGRAM);
    cg(8'h00, 8'h9f, 4'h7, 16'h4cff, SRC_CGRAM);
    cg(8'h00, 8'ha0, 4'h0, 16'h00a0, SRC_INT_ROM);
    cg(8'h00, 8'he0, 4'h1, 16'h4f01, SRC_CGRAM);
    cg(8'h02, 8'he0, 4'h1, 16'h4d01, SRC_CGRAM);
    cg(8'h04, 8'h80, 4'h9, 16'h5009, SRC_CGRAM);
    cg(8'h01, 8'h41, 4'h3, 16'hf20b, SRC_EXT_ROM);
    cg(8'h05, 8'h7f, 4'hf, 16'hf7ff, SRC_EXT_ROM);
    axi_wr(OFS_CG_BASE, 32'hf000);
    cg(8'h00, 8'h80, 4'h0, 16'hf400, SRC_CGRAM);
    $display("test char generator done");
    test_done();
  end
endmodule
